// file: hw/lcd_consts.svh
// Constants for the dot-matrix LCD driver control block
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// Display memory offsets from the base of the display window (F000H)
`define LCD_MEM_BASE        16'hF000
`define LCD_REGION_PAGE0    2'h0
`define LCD_REGION_PAGE1    2'h1
`define LCD_REGION_ROW16    2'h2
`define LCD_PAGE_WORDS      8'h78
`define LCD_ROW16_LAST      8'h76

// Panel geometry
`define LCD_NUM_COMMONS     17
`define LCD_NUM_SEGMENTS    60
`define LCD_COM_LAST_DUTY17 5'h10
`define LCD_COM_LAST_DUTY16 5'h0F
`define LCD_COM_LAST_DUTY8  5'h07

// Control reset values
`define LCD_RST_SUPPLY_EN   1'b0
`define LCD_RST_REF_SEL     1'b0
`define LCD_RST_ALL_ON      1'b0
`define LCD_RST_ALL_OFF     1'b1
`define LCD_RST_DUTY_HI     1'b0
`define LCD_RST_DUTY_LO     1'b0
`define LCD_RST_PAGE        1'b0
`define LCD_RST_CONTRAST    4'h0

// Timing
`define LCD_CLK_HZ          200000000
`define LCD_OSC_HZ          32768
`define LCD_SETTLE_MS       100
`define LCD_SETTLE_CYC      ((`LCD_CLK_HZ / 1000) * `LCD_SETTLE_MS)
`define LCD_SLOT_LAST_NARROW 7'h3F
`define LCD_SLOT_LAST_WIDE  7'h7F

`endif

// file: hw/lcd_drive_cell.sv
// Level selector for one common or segment pin under 1/4 bias
`timescale 1ns/1ps
`default_nettype none

module lcd_drive_cell
    import lcd_pkg::*;
#(
    parameter bit IS_COMMON = 1'b0
)(
    input  wire logic powered,
    input  wire logic active,
    input  wire logic phase,
    output lcd_level_t level
);

    // Common select 4/0, non-select 1/3; segment on 0/4, off 2/2 in VC1 units
    always_comb begin
        if (!powered) begin
            level = LCD_LV_VSS;
        end else if (IS_COMMON) begin
            if (active) begin
                level = phase ? LCD_LV_VSS : LCD_LV_VC5;
            end else begin
                level = phase ? LCD_LV_VC4 : LCD_LV_VC1;
            end
        end else begin
            if (active) begin
                level = phase ? LCD_LV_VC5 : LCD_LV_VSS;
            end else begin
                level = LCD_LV_VC2;
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/lcd_driver.sv
// Dot-matrix LCD driver control: settings, display memory and scan
//
// Operation
// - Seventeen commons, sixty segments, 1,020 dots.
// - Dynamic drive at 1/17, 1/16, 1/8, 1/4 bias.
// - Reference select: 1 second, 0 first; reset 0.
// - No force bits: segments follow display memory.
// - Both force bits set: all-on wins.
// - Duty field: 1x 1/8, 01 1/16, 00 1/17.
// - Frame 32 Hz, or 30.12 Hz at 1/17.
// - Display memory at F000H, bits map to dots.
// - Bit one lights dot, zero leaves dark.
// - 1/17 shows seventeen commons, 1/16 first sixteen.
// - At 1/8, page bit picks F000H or F100H.
// - Page change shows at once, no refresh.
// - Memory undefined after reset; software fills it.
// - Memory read/write; spare locations are general storage.
// - Four-bit contrast code, sixteen levels, light to dark.
// - Contrast scales chosen reference; others follow proportionally.
// - Contrast undefined after reset; software writes it. Here reset loads contrast 0.
// - Supply off grounds levels; settle about 100 msec.
// - Reset clears supply enable, sets force-all-off.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_consts.svh"

module lcd_driver
    import lcd_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = `LCD_SETTLE_CYC
)(
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Control bits, loaded together on cfg_write
    input  wire logic               cfg_write,
    input  wire logic               drive_supply_enable,
    input  wire logic               reference_select,
    input  wire logic               force_all_on,
    input  wire logic               force_all_off,
    input  wire logic               duty_select_hi,
    input  wire logic               duty_select_lo,
    input  wire logic               page_select,
    input  wire logic [3:0]         contrast_level,
    // Display memory port, address is the offset from F000H
    input  wire logic               mem_en,
    input  wire logic               mem_we,
    input  wire logic [9:0]         mem_addr,
    input  wire logic [3:0]         mem_wdata,
    output logic      [3:0]         mem_rdata,
    // Control readback
    output logic                    ctrl_supply_enable,
    output logic                    ctrl_reference_select,
    output logic                    ctrl_force_all_on,
    output logic                    ctrl_force_all_off,
    output logic      [1:0]         ctrl_duty,
    output logic                    ctrl_page_select,
    // Drive-voltage generator
    output logic                    generator_enable,
    output logic                    generator_ref_select,
    output logic      [3:0]         generator_contrast,
    output logic                    levels_ready,
    // Panel
    output lcd_level_t [16:0]       common_outputs,
    output lcd_level_t [59:0]       segment_outputs,
    output logic      [4:0]         scan_common,
    output logic                    frame_start
);

    localparam int NCOM = `LCD_NUM_COMMONS;
    localparam int NSEG = `LCD_NUM_SEGMENTS;
    localparam logic [24:0] SETTLE_LAST = 25'(SETTLE_CYCLES - 1);

    lcd_regs_t r;
    lcd_regs_t next_r;

    // Display memory: no reset, contents undefined until software writes
    logic [3:0] page0_mem [0:119];
    logic [3:0] page1_mem [0:119];
    logic [3:0] row16_mem [0:59];

    logic             osc_tick;
    logic             duty8;
    logic [4:0]       com_last;
    logic [6:0]       slot_last;
    logic             phase;
    logic             powered;
    logic [1:0]       region;
    logic [7:0]       low_addr;
    logic             addr_hit;
    logic [6:0]       word_idx;
    logic [3:0]       read_word;
    logic [NSEG-1:0]  seg_bit;
    logic [NSEG-1:0]  seg_on;
    logic [NCOM-1:0]  com_sel;
    lcd_level_t [16:0] com_lv_w;
    lcd_level_t [59:0] seg_lv_w;

    lcd_osc_tick u_osc_tick (
        .clock    (clock),
        .rst_n    (rst_n),
        .osc_tick (osc_tick)
    );

    // Duty decode; low bit ignored when high bit set
    always_comb begin
        duty8 = r.duty_hi;
        if (r.duty_hi) begin
            com_last = `LCD_COM_LAST_DUTY8;
        end else if (r.duty_lo) begin
            com_last = `LCD_COM_LAST_DUTY16;
        end else begin
            com_last = `LCD_COM_LAST_DUTY17;
        end
        // 64 oscillator ticks per common, 128 at 1/8: 32 Hz, 32 Hz, 30.12 Hz
        slot_last = duty8 ? `LCD_SLOT_LAST_WIDE : `LCD_SLOT_LAST_NARROW;
        // Polarity flips halfway through each slot so no pin sees DC
        phase     = duty8 ? r.tick_cnt[6] : r.tick_cnt[5];
        // Levels grounded while supply is off
        powered   = r.supply_en && (r.state != LCD_ST_OFF);
    end

    // Address decode: F000-F077, F100-F177, even words F200-F276
    always_comb begin
        region   = mem_addr[9:8];
        low_addr = mem_addr[7:0];
        addr_hit = 1'b0;
        word_idx = '0;
        unique case (region)
            `LCD_REGION_PAGE0, `LCD_REGION_PAGE1: begin
                addr_hit = low_addr < `LCD_PAGE_WORDS;
                word_idx = low_addr[6:0];
            end
            `LCD_REGION_ROW16: begin
                addr_hit = !low_addr[0] && (low_addr <= `LCD_ROW16_LAST);
                word_idx = {1'b0, low_addr[6:1]};
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Holes are software's to avoid; here they read zero and drop writes
    always_comb begin
        read_word = '0;
        if (addr_hit) begin
            if (region == `LCD_REGION_PAGE0) begin
                read_word = page0_mem[word_idx];
            end else if (region == `LCD_REGION_PAGE1) begin
                read_word = page1_mem[word_idx];
            end else begin
                read_word = row16_mem[word_idx[5:0]];
            end
        end
    end

    // All four bits of every word are stored, spare bits act as storage
    always_ff @(posedge clock) begin
        if (mem_en && mem_we && addr_hit) begin
            if (region == `LCD_REGION_PAGE0) begin
                page0_mem[word_idx] <= mem_wdata;
            end else if (region == `LCD_REGION_PAGE1) begin
                page1_mem[word_idx] <= mem_wdata;
            end else begin
                row16_mem[word_idx[5:0]] <= mem_wdata;
            end
        end
    end

    // Segment s at common c: word 2s+c[2], bit c[1:0] of the page for that row
    always_comb begin
        seg_bit = '0;
        for (int s = 0; s < NSEG; s++) begin
            if (r.com_idx == 5'h10) begin
                seg_bit[s] = row16_mem[s][0];
            end else if (r.com_idx[3]) begin
                seg_bit[s] = page1_mem[2 * s + int'(r.com_idx[2])][r.com_idx[1:0]];
            end else if (duty8 && r.page) begin
                // Page read live from the register, so a flip shows at once
                seg_bit[s] = page1_mem[2 * s + int'(r.com_idx[2])][r.com_idx[1:0]];
            end else begin
                seg_bit[s] = page0_mem[2 * s + int'(r.com_idx[2])][r.com_idx[1:0]];
            end
        end
    end

    // Force priority: all-on over all-off over memory
    always_comb begin
        for (int s = 0; s < NSEG; s++) begin
            if (r.all_on) begin
                seg_on[s] = 1'b1;
            end else if (r.all_off) begin
                seg_on[s] = 1'b0;
            end else begin
                seg_on[s] = seg_bit[s];
            end
        end
    end

    // Only the common of the current slot is selected; unused ones stay non-select
    always_comb begin
        for (int c = 0; c < NCOM; c++) begin
            com_sel[c] = (r.com_idx == 5'(c)) && (5'(c) <= com_last);
        end
    end

    // One level cell per pin: 17 commons, 60 segments
    genvar gc;
    generate
        for (gc = 0; gc < NCOM; gc++) begin : g_com
            lcd_drive_cell #(
                .IS_COMMON (1'b1)
            ) u_cell (
                .powered (powered),
                .active  (com_sel[gc]),
                .phase   (phase),
                .level   (com_lv_w[gc])
            );
        end
        for (gc = 0; gc < NSEG; gc++) begin : g_seg
            lcd_drive_cell #(
                .IS_COMMON (1'b0)
            ) u_cell (
                .powered (powered),
                .active  (seg_on[gc]),
                .phase   (phase),
                .level   (seg_lv_w[gc])
            );
        end
    endgenerate

    always_comb begin
        next_r             = r;
        next_r.frame_start = 1'b0;
        next_r.com_lv      = com_lv_w;
        next_r.seg_lv      = seg_lv_w;

        if (cfg_write) begin
            next_r.supply_en = drive_supply_enable;
            next_r.ref_sel   = reference_select;
            next_r.all_on    = force_all_on;
            next_r.all_off   = force_all_off;
            next_r.duty_hi   = duty_select_hi;
            next_r.duty_lo   = duty_select_lo;
            next_r.page      = page_select;
            next_r.contrast  = contrast_level;
        end

        if (mem_en && !mem_we) begin
            next_r.rdata = read_word;
        end

        // Generator power sequencing
        unique case (r.state)
            LCD_ST_OFF: begin
                if (r.supply_en) begin
                    next_r.state      = LCD_ST_SETTLE;
                    next_r.settle_cnt = '0;
                end
            end
            LCD_ST_SETTLE: begin
                if (!r.supply_en) begin
                    next_r.state = LCD_ST_OFF;
                end else if (r.settle_cnt == SETTLE_LAST) begin
                    next_r.state = LCD_ST_RUN;
                end else begin
                    next_r.settle_cnt = r.settle_cnt + 25'h1;
                end
            end
            LCD_ST_RUN: begin
                if (!r.supply_en) begin
                    next_r.state = LCD_ST_OFF;
                end
            end
        endcase

        // Scan: ascending commons, one slot each, wrap at the duty's last
        if (r.state == LCD_ST_OFF) begin
            next_r.tick_cnt = '0;
            next_r.com_idx  = '0;
        end else if (r.com_idx > com_last) begin
            // Duty narrowed mid-frame: restart rather than scan a dead common
            next_r.tick_cnt = '0;
            next_r.com_idx  = '0;
        end else if (osc_tick) begin
            if (r.tick_cnt >= slot_last) begin
                next_r.tick_cnt = '0;
                if (r.com_idx == com_last) begin
                    next_r.com_idx     = '0;
                    next_r.frame_start = 1'b1;
                end else begin
                    next_r.com_idx = r.com_idx + 5'h1;
                end
            end else begin
                next_r.tick_cnt = r.tick_cnt + 7'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r             <= '0;
            r.state       <= LCD_ST_OFF;
            r.supply_en   <= `LCD_RST_SUPPLY_EN;
            r.ref_sel     <= `LCD_RST_REF_SEL;
            r.all_on      <= `LCD_RST_ALL_ON;
            r.all_off     <= `LCD_RST_ALL_OFF;
            r.duty_hi     <= `LCD_RST_DUTY_HI;
            r.duty_lo     <= `LCD_RST_DUTY_LO;
            r.page        <= `LCD_RST_PAGE;
            r.contrast    <= `LCD_RST_CONTRAST;
        end else begin
            r <= next_r;
        end
    end

    assign mem_rdata             = r.rdata;
    assign ctrl_supply_enable    = r.supply_en;
    assign ctrl_reference_select = r.ref_sel;
    assign ctrl_force_all_on     = r.all_on;
    assign ctrl_force_all_off    = r.all_off;
    assign ctrl_duty             = {r.duty_hi, r.duty_lo};
    assign ctrl_page_select      = r.page;
    assign generator_enable      = r.supply_en;
    // Analog side regulates the chosen reference to this code; others scale from it
    assign generator_ref_select  = r.ref_sel;
    assign generator_contrast    = r.contrast;
    assign levels_ready          = (r.state == LCD_ST_RUN);
    assign common_outputs        = r.com_lv;
    assign segment_outputs       = r.seg_lv;
    assign scan_common           = r.com_idx;
    assign frame_start           = r.frame_start;

endmodule
`default_nettype wire

// file: hw/lcd_osc_tick.sv
// Fractional divider giving a 32.768 kHz enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "lcd_consts.svh"

module lcd_osc_tick
    import lcd_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    output logic      osc_tick
);

    localparam logic [27:0] STEP    = 28'(`LCD_OSC_HZ);
    localparam logic [27:0] MODULUS = 28'(`LCD_CLK_HZ);

    lcd_tick_regs_t r;
    lcd_tick_regs_t next_r;

    // Phase accumulator keeps the long-term rate exact; jitter is one clock
    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (r.acc + STEP >= MODULUS) begin
            next_r.acc  = r.acc + STEP - MODULUS;
            next_r.tick = 1'b1;
        end else begin
            next_r.acc = r.acc + STEP;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign osc_tick = r.tick;

endmodule
`default_nettype wire

// file: hw/lcd_pkg.sv
// Types shared by the LCD driver control files
package lcd_pkg;

    // Drive level selected onto a common or segment pin
    typedef enum logic [2:0] {
        LCD_LV_VSS = 3'h0,
        LCD_LV_VC1 = 3'h1,
        LCD_LV_VC2 = 3'h2,
        LCD_LV_VC4 = 3'h3,
        LCD_LV_VC5 = 3'h4
    } lcd_level_t;

    typedef enum logic [2:0] {
        LCD_ST_OFF    = 3'b001,
        LCD_ST_SETTLE = 3'b010,
        LCD_ST_RUN    = 3'b100
    } lcd_state_t;

    typedef struct packed {
        lcd_state_t        state;
        logic              supply_en;
        logic              ref_sel;
        logic              all_on;
        logic              all_off;
        logic              duty_hi;
        logic              duty_lo;
        logic              page;
        logic [3:0]        contrast;
        logic [24:0]       settle_cnt;
        logic [6:0]        tick_cnt;
        logic [4:0]        com_idx;
        logic              frame_start;
        logic [3:0]        rdata;
        lcd_level_t [16:0] com_lv;
        lcd_level_t [59:0] seg_lv;
    } lcd_regs_t;

    typedef struct packed {
        logic [27:0] acc;
        logic        tick;
    } lcd_tick_regs_t;

endpackage

// file: sim/lcd_driver_asserts.sv
// Concurrent checks on the LCD driver control ports
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_asserts
    import lcd_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = 20
)(
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              cfg_write,
    input wire logic              drive_supply_enable,
    input wire logic              reference_select,
    input wire logic              duty_select_hi,
    input wire logic              duty_select_lo,
    input wire logic              page_select,
    input wire logic [3:0]        contrast_level,
    input wire logic              ctrl_supply_enable,
    input wire logic              ctrl_reference_select,
    input wire logic              ctrl_force_all_on,
    input wire logic              ctrl_force_all_off,
    input wire logic [1:0]        ctrl_duty,
    input wire logic              ctrl_page_select,
    input wire logic              generator_enable,
    input wire logic              generator_ref_select,
    input wire logic [3:0]        generator_contrast,
    input wire logic              levels_ready,
    input wire lcd_level_t [16:0] common_outputs,
    input wire lcd_level_t [59:0] segment_outputs,
    input wire logic [4:0]        scan_common
);
    logic [24:0] on_cnt;
    logic [16:0] com_sel;
    logic [59:0] seg_off;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Saturates so a long powered run never wraps back under the settle time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt <= '0;
        end else if (!generator_enable) begin
            on_cnt <= '0;
        end else if (on_cnt != '1) begin
            on_cnt <= on_cnt + 25'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 17; i++) com_sel[i] = common_outputs[i] inside {LCD_LV_VC5, LCD_LV_VSS};
        for (int i = 0; i < 60; i++) seg_off[i] = segment_outputs[i] == LCD_LV_VC2;
    end
    a_supply_load: assert property (
        cfg_write |=> generator_enable == $past(drive_supply_enable)
            && ctrl_supply_enable == $past(drive_supply_enable)) else $error("supply bit lost");
    a_ref_load: assert property (
        cfg_write |=> generator_ref_select == $past(reference_select)
            && ctrl_reference_select == $past(reference_select)) else $error("reference lost");
    a_contrast_load: assert property (
        cfg_write |=> generator_contrast == $past(contrast_level)) else $error("contrast lost");
    a_duty_page: assert property (
        cfg_write |=> ctrl_duty == {$past(duty_select_hi), $past(duty_select_lo)}
            && ctrl_page_select == $past(page_select)) else $error("duty or page lost");
    a_off_ground: assert property (
        !generator_enable [*3] |-> !levels_ready && common_outputs == '0
            && segment_outputs == '0) else $error("levels not grounded");
    a_settle_min: assert property (
        levels_ready |-> on_cnt >= SETTLE_CYCLES) else $error("ready too early");
    a_settle_max: assert property (
        on_cnt > SETTLE_CYCLES + 3 |-> levels_ready) else $error("ready too late");
    a_one_common: assert property (
        levels_ready |-> $countones(com_sel) == 1 && com_sel[$past(scan_common)])
        else $error("common select wrong");
    a_force_on: assert property (
        ctrl_force_all_on [*2] ##0 levels_ready |-> seg_off == '0) else $error("dot left off");
    a_force_off: assert property (
        (ctrl_force_all_off && !ctrl_force_all_on) [*2] ##0 levels_ready |-> &seg_off)
        else $error("dot left on");
endmodule
bind lcd_driver lcd_driver_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) lcd_driver_asserts_i (
    .clock(clock), .rst_n(rst_n), .cfg_write(cfg_write),
    .drive_supply_enable(drive_supply_enable), .reference_select(reference_select),
    .duty_select_hi(duty_select_hi), .duty_select_lo(duty_select_lo),
    .page_select(page_select), .contrast_level(contrast_level),
    .ctrl_supply_enable(ctrl_supply_enable), .ctrl_reference_select(ctrl_reference_select),
    .ctrl_force_all_on(ctrl_force_all_on), .ctrl_force_all_off(ctrl_force_all_off),
    .ctrl_duty(ctrl_duty), .ctrl_page_select(ctrl_page_select),
    .generator_enable(generator_enable), .generator_ref_select(generator_ref_select),
    .generator_contrast(generator_contrast), .levels_ready(levels_ready),
    .common_outputs(common_outputs), .segment_outputs(segment_outputs),
    .scan_common(scan_common)
);
`default_nettype wire

// file: sim/lcd_panel_model.sv
// Behavioural dot-matrix panel: reports which dots appear lit
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
    import lcd_pkg::*;
(
    input  wire lcd_level_t [16:0] common_outputs,
    input  wire lcd_level_t [59:0] segment_outputs,
    output logic [59:0]            lit,
    output logic [4:0]             sel_com,
    output logic [4:0]             sel_count
);
    int sel;
    always_comb begin
        sel = 0;
        sel_count = 5'h00;
        for (int c = 16; c >= 0; c--) begin
            if (common_outputs[c] inside {LCD_LV_VC5, LCD_LV_VSS}) begin
                sel = c;
                sel_count = sel_count + 5'h01;
            end
        end
        sel_com = 5'(sel);
        // Only the full four-step swing across a dot turns it on
        for (int s = 0; s < 60; s++)
            lit[s] = (int'(common_outputs[sel]) - int'(segment_outputs[s])) inside {4, -4};
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the LCD driver control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lcd_pkg::*;
    localparam int unsigned SETTLE = 20;
    // Config word: supply, ref, all-on, all-off, duty hi, duty lo, page, contrast
    localparam logic [10:0] MODES [8] = '{11'h407, 11'h427, 11'h457, 11'h467,
                                          11'h417, 11'h507, 11'h587, 11'h487};
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              cfg_write = 1'b0;
    logic [10:0]       cfg = 11'h080;
    logic              mem_en = 1'b0;
    logic              mem_we = 1'b0;
    logic [9:0]        mem_addr = 10'h000;
    logic [3:0]        mem_wdata = 4'h0;
    logic [3:0]        mem_rdata;
    logic              ctrl_supply_enable, ctrl_reference_select, ctrl_page_select;
    logic              ctrl_force_all_on, ctrl_force_all_off, generator_enable;
    logic              generator_ref_select, levels_ready, frame_start;
    logic [1:0]        ctrl_duty;
    logic [3:0]        generator_contrast;
    logic [4:0]        scan_common, sel_com, sel_count;
    logic [59:0]       lit;
    lcd_level_t [16:0] common_outputs;
    lcd_level_t [59:0] segment_outputs;
    logic [3:0]        mem_model [0:1023];
    logic [15:0]       lfsr = 16'hCF4A;
    int                num_errors = 0;
    int                checks_done = 0;
    lcd_driver #(.SETTLE_CYCLES(SETTLE)) lcd_driver_i (
        .clock(clock), .rst_n(rst_n), .cfg_write(cfg_write),
        .drive_supply_enable(cfg[10]), .reference_select(cfg[9]),
        .force_all_on(cfg[8]), .force_all_off(cfg[7]), .duty_select_hi(cfg[6]),
        .duty_select_lo(cfg[5]), .page_select(cfg[4]), .contrast_level(cfg[3:0]),
        .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .ctrl_supply_enable(ctrl_supply_enable),
        .ctrl_reference_select(ctrl_reference_select), .ctrl_force_all_on(ctrl_force_all_on),
        .ctrl_force_all_off(ctrl_force_all_off), .ctrl_duty(ctrl_duty),
        .ctrl_page_select(ctrl_page_select), .generator_enable(generator_enable),
        .generator_ref_select(generator_ref_select), .generator_contrast(generator_contrast),
        .levels_ready(levels_ready), .common_outputs(common_outputs),
        .segment_outputs(segment_outputs), .scan_common(scan_common), .frame_start(frame_start)
    );
    lcd_panel_model lcd_panel_model_i (
        .common_outputs(common_outputs), .segment_outputs(segment_outputs),
        .lit(lit), .sel_com(sel_com), .sel_count(sel_count)
    );
    always #2.5 clock = ~clock;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Row shown on common 0 in the first half of its slot
    function automatic logic [59:0] exp_row(input logic [10:0] v);
        logic [59:0] r;
        for (int s = 0; s < 60; s++)
            r[s] = mem_model[{1'b0, v[6] & v[4], 8'(2 * s)}][0];
        if (v[8]) r = '1;
        else if (v[7]) r = '0;
        return r;
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic set_cfg(input logic [10:0] v);
        @(posedge clock) #1;
        cfg = v;
        cfg_write = 1'b1;
        @(posedge clock) #1;
        cfg_write = 1'b0;
    endtask
    task automatic mem(input logic we, input logic [9:0] a, input logic [3:0] d);
        @(posedge clock) #1;
        {mem_en, mem_we, mem_addr, mem_wdata} = {1'b1, we, a, d};
        @(posedge clock) #1;
        mem_en = 1'b0;
    endtask
    initial begin
        int n;
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        @(posedge clock) #1;
        check({ctrl_supply_enable, ctrl_reference_select, ctrl_force_all_on, ctrl_force_all_off,
               ctrl_duty, ctrl_page_select}, 7'h08, "reset ctrl");
        check({|common_outputs, |segment_outputs, levels_ready}, 3'h0, "reset pins");
        // Pass 0 fills every mapped word, pass 1 reads it back; holes are skipped
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 760; k++)
                if (k[7:0] < 8'h78 && !(k[9] && k[0])) begin
                    if (p == 0) begin
                        lfsr = lfsr_next(lfsr);
                        mem_model[k] = lfsr[3:0];
                    end
                    mem(p == 0, 10'(k), mem_model[k]);
                    if (p == 1) check(mem_rdata, mem_model[k], "readback");
                end
        for (int c = 0; c < 16; c++) begin
            set_cfg({1'b0, c[0], 2'b01, c[1:0], c[2], c[3:0]});
            check({generator_contrast, generator_ref_select, ctrl_duty, ctrl_page_select},
                  {c[3:0], c[0], c[1:0], c[2]}, "ctrl load");
            check({|segment_outputs, generator_enable}, 2'h0, "unpowered");
        end
        set_cfg(11'h487);
        check(generator_enable, 1'b1, "generator");
        n = 0;
        while (levels_ready !== 1'b1 && n < 100) begin
            @(posedge clock) #1;
            n++;
        end
        check(n >= SETTLE && n <= SETTLE + 4, 1'b1, "settle");
        if (n == 100) end_of_test();
        check(lit, 60'h0, "blank");
        // One cycle after each change, so a page flip must already show
        foreach (MODES[m]) begin
            set_cfg(MODES[m]);
            @(posedge clock) #1;
            check(lit, exp_row(MODES[m]), "row");
            check({sel_count, sel_com, common_outputs[0]}, {5'h01, 5'h00, LCD_LV_VC5}, "com");
        end
        set_cfg(11'h407);
        mem_model[0] = ~mem_model[0];
        mem(1'b1, 10'h000, mem_model[0]);
        @(posedge clock) #1;
        check(lit, exp_row(11'h407), "live");
        set_cfg(11'h007);
        repeat (2) @(posedge clock);
        #1;
        check({|common_outputs, |segment_outputs, levels_ready}, 3'h0, "grounded");
        end_of_test();
    end
endmodule
`default_nettype wire
